//--- kms_pkg.sv
// package: constants for the keyboard matrix scanner
package kms_pkg;
    localparam logic [7:0] KMS_ADDR_XLAT     = 8'h60;
    localparam logic [7:0] KMS_ADDR_KEY      = 8'h7D;
    localparam logic [7:0] KMS_BREAK_OFS     = 8'h80;
    localparam int         KMS_CLK_HZ        = 20000000;
    localparam int         KMS_DEBOUNCE_MS   = 5;
    localparam int         KMS_DELAY_MS      = 500;
    localparam int         KMS_REPEAT_MS     = 100;
    localparam int         KMS_DEBOUNCE_CYC  = KMS_CLK_HZ / 1000 * KMS_DEBOUNCE_MS;
    localparam int         KMS_DELAY_CYC     = KMS_CLK_HZ / 1000 * KMS_DELAY_MS;
    localparam int         KMS_REPEAT_CYC    = KMS_CLK_HZ / 1000 * KMS_REPEAT_MS;
    localparam int         KMS_SETTLE_CYC    = 4;
    localparam int         KMS_ROWS          = 8;
    localparam int         KMS_COLS          = 10;
    localparam int         KMS_KEYS          = 79;
    localparam logic [7:0] KMS_RESET_CODE    = 8'h00;
endpackage

//--- kms_code_rom.sv
// module: key position to internal make code lookup
`timescale 1ns/1ps
module kms_code_rom (
    input  wire logic [6:0] key_idx,
    output logic      [7:0] make_code
);
    // ---------------------------------------------------------------
    // fixed position map, index = key number - 1
    // ---------------------------------------------------------------
    localparam logic [7:0] KMS_MAP [0:79] = '{
        8'h11, 8'h12, 8'h13, 8'h14, 8'h15, 8'h16, 8'h17, 8'h18, 8'h19, 8'h1A,
        8'h1B, 8'h1C, 8'h1D, 8'h1E, 8'h1F, 8'h21, 8'h22, 8'h23, 8'h24, 8'h25,
        8'h26, 8'h27, 8'h28, 8'h29, 8'h2A, 8'h2B, 8'h2C, 8'h2D, 8'h2E, 8'h31,
        8'h32, 8'h33, 8'h34, 8'h35, 8'h36, 8'h37, 8'h38, 8'h39, 8'h3A, 8'h3B,
        8'h3C, 8'h3D, 8'h3E, 8'h41, 8'h54, 8'h42, 8'h43, 8'h44, 8'h45, 8'h46,
        8'h47, 8'h48, 8'h49, 8'h4A, 8'h4B, 8'h4C, 8'h4E, 8'h51, 8'h52, 8'h53,
        8'h56, 8'h5A, 8'h5B, 8'h5C, 8'h5E, 8'h5F, 8'h01, 8'h02, 8'h03, 8'h04,
        8'h05, 8'h06, 8'h07, 8'h08, 8'h09, 8'h0A, 8'h0B, 8'h0C, 8'h0D, 8'h0E
    };
    always_comb begin
        if (key_idx < 7'd80) begin
            make_code = KMS_MAP[key_idx];
        end else begin
            make_code = 8'h00;
        end
    end
endmodule

//--- kms_scanner.sv
// module: keyboard matrix scanner with debounce, typematic and code registers
// Notes on behaviour
// - valid keystroke loads code register at 07D and raises nonmaskable interrupt.
// - after a keystroke scanning halts until the code register is read.
// - a key change is reported only if still present after 5 ms.
// - any key press arms a 500 ms typematic delay.
// - held key repeats after the delay, then every 100 ms.
// - repeat stops when the key is released or another key pressed.
// - pressing another key restarts the full 500 ms delay.
// - raw internal codes only, no translation and no queue.
// - drive matrix columns and sense rows for 78 or 79 keys.
// - release reports the make code plus hex 80.
// - each key position maps to a fixed internal make code.
// - a write to register 060 raises a level-1 interrupt request.
// - register 060 holds eight bits, bit 7 most significant.
`timescale 1ns/1ps
module kms_scanner
    import kms_pkg::*;
#(
    parameter int ROWS         = kms_pkg::KMS_ROWS,
    parameter int COLS         = kms_pkg::KMS_COLS,
    parameter int DEBOUNCE_CYC = kms_pkg::KMS_DEBOUNCE_CYC,
    parameter int DELAY_CYC    = kms_pkg::KMS_DELAY_CYC,
    parameter int REPEAT_CYC   = kms_pkg::KMS_REPEAT_CYC
) (
    input  wire logic            ref_clk,
    input  wire logic            sys_rst,
    output logic [COLS-1:0]      drive_n_r,
    input  wire logic [ROWS-1:0] sense_n,
    input  wire logic [7:0]      io_addr,
    input  wire logic [7:0]      io_wdata,
    input  wire logic            io_wr,
    input  wire logic            io_rd,
    output logic [7:0]           io_rdata_r,
    output logic                 nmi_r,
    output logic                 irq1_r
);
    import kms_pkg::*;

    typedef enum logic [3:0] {
        KMS_SCAN   = 4'b0001,
        KMS_BOUNCE = 4'b0010,
        KMS_SHOW   = 4'b0100,
        KMS_HALT   = 4'b1000
    } kms_state_e;

    // ---------------------------------------------------------------
    // sense synchroniser and column scan
    // ---------------------------------------------------------------
    logic [ROWS-1:0] sense_s1_r;
    logic [ROWS-1:0] sense_s2_r;
    logic [3:0]      col_r;
    logic [2:0]      settle_r;
    logic [ROWS-1:0] hit_r;
    kms_state_e      state_r;
    logic [6:0]      cand_r;
    logic            cand_press_r;
    logic [6:0]      held_r;
    logic            held_v_r;
    logic [31:0]     tmr_r;
    logic [31:0]     typ_r;
    logic            typ_due_r;
    logic [7:0]      key_r;
    logic [7:0]      xlat_r;
    logic [7:0]      make_code;
    logic [6:0]      row_hit;
    logic            row_any;
    logic            sample;
    logic [6:0]      scan_key;
    logic            pressed;
    logic            rd_key;
    logic            cand_now;

    logic [ROWS*COLS-1:0] down_r;

    function automatic logic [6:0] kms_key(input logic [3:0] c, input logic [2:0] r);
        kms_key = 7'(c * ROWS + r);
    endfunction

    always_ff @(posedge ref_clk) begin
        sense_s1_r <= sense_n;
        sense_s2_r <= sense_s1_r;
    end

    assign sample = (settle_r == 3'(KMS_SETTLE_CYC - 1));

    always_comb begin
        row_hit = 7'd0;
        row_any = 1'b0;
        for (int i = ROWS - 1; i >= 0; i--) begin
            if ((!sense_s2_r[i]) != down_r[kms_key(col_r, 3'(i))]) begin
                row_hit = 7'(i);
                row_any = 1'b1;
            end
        end
    end

    assign scan_key = kms_key(col_r, row_hit[2:0]);
    // sensed level of the first changed key in this column
    assign pressed  = !sense_s2_r[row_hit[2:0]];
    assign cand_now = !sense_s2_r[3'(cand_r % 7'(ROWS))];
    assign rd_key   = io_rd && (io_addr == KMS_ADDR_KEY);

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            col_r     <= 4'd0;
            settle_r  <= 3'd0;
            drive_n_r <= {COLS{1'b1}};
        end else if (state_r == KMS_SCAN || state_r == KMS_BOUNCE) begin
            drive_n_r <= ~(COLS'(1) << col_r);
            if (sample) begin
                settle_r <= 3'd0;
                col_r    <= (col_r == 4'(COLS - 1)) ? 4'd0 : col_r + 4'd1;
            end else begin
                settle_r <= settle_r + 3'd1;
            end
        end else begin
            drive_n_r <= {COLS{1'b1}};
            settle_r  <= 3'd0;
        end
    end

    kms_code_rom u_rom (
        .key_idx   (state_r == KMS_SHOW ? cand_r : held_r),
        .make_code (make_code)
    );

    // ---------------------------------------------------------------
    // detection, debounce and presentation
    // ---------------------------------------------------------------
    logic change;
    assign change = sample && row_any;

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            state_r      <= KMS_SCAN;
            cand_r       <= 7'd0;
            cand_press_r <= 1'b0;
            tmr_r        <= 32'd0;
            key_r        <= KMS_RESET_CODE;
            nmi_r        <= 1'b0;
            held_r       <= 7'd0;
            held_v_r     <= 1'b0;
            down_r       <= '0;
        end else begin
            case (state_r)
                KMS_SCAN: begin
                    if (change) begin
                        cand_r       <= scan_key;
                        cand_press_r <= pressed;
                        tmr_r        <= 32'd0;
                        state_r      <= KMS_BOUNCE;
                    end else if (typ_due_r && held_v_r) begin
                        cand_r       <= held_r;
                        cand_press_r <= 1'b1;
                        state_r      <= KMS_SHOW;
                    end
                end
                KMS_BOUNCE: begin
                    if (tmr_r >= 32'(DEBOUNCE_CYC - 1)) begin
                        if (sample && col_r == 4'(cand_r / 7'(ROWS))) begin
                            if (cand_now == cand_press_r) begin
                                state_r <= KMS_SHOW;
                            end else begin
                                state_r <= KMS_SCAN;
                            end
                        end
                    end else begin
                        tmr_r <= tmr_r + 32'd1;
                    end
                end
                KMS_SHOW: begin
                    // raw code, single holding register
                    key_r    <= cand_press_r ? make_code : make_code + KMS_BREAK_OFS;
                    nmi_r    <= 1'b1;
                    held_r   <= cand_r;
                    held_v_r <= cand_press_r;
                    down_r[cand_r] <= cand_press_r;
                    state_r  <= KMS_HALT;
                end
                KMS_HALT: begin
                    if (rd_key) begin
                        nmi_r   <= 1'b0;
                        state_r <= KMS_SCAN;
                    end
                end
                default: state_r <= KMS_SCAN;
            endcase
        end
    end

    // ---------------------------------------------------------------
    // typematic timer
    // ---------------------------------------------------------------
    logic new_press;
    assign new_press = (state_r == KMS_SHOW) && cand_press_r && (!held_v_r || cand_r != held_r);

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            typ_r     <= 32'd0;
            typ_due_r <= 1'b0;
        end else if (new_press) begin
            typ_r     <= 32'(DELAY_CYC - 1);
            typ_due_r <= 1'b0;
        end else if (state_r == KMS_SHOW && !cand_press_r) begin
            typ_due_r <= 1'b0;
            typ_r     <= 32'd0;
        end else if (state_r == KMS_SHOW) begin
            typ_r     <= 32'(REPEAT_CYC - 1);
            typ_due_r <= 1'b0;
        end else if (held_v_r && !typ_due_r) begin
            if (typ_r == 32'd0) begin
                typ_due_r <= 1'b1;
            end else begin
                typ_r <= typ_r - 32'd1;
            end
        end
    end

    // ---------------------------------------------------------------
    // register access
    // ---------------------------------------------------------------
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            xlat_r <= KMS_RESET_CODE;
            irq1_r <= 1'b0;
        end else if (io_wr && io_addr == KMS_ADDR_XLAT) begin
            xlat_r <= io_wdata;
            irq1_r <= 1'b1;
        end else if (io_rd && io_addr == KMS_ADDR_XLAT) begin
            irq1_r <= 1'b0;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            io_rdata_r <= 8'h00;
        end else if (io_addr == KMS_ADDR_KEY) begin
            io_rdata_r <= key_r;
        end else if (io_addr == KMS_ADDR_XLAT) begin
            io_rdata_r <= xlat_r;
        end else begin
            io_rdata_r <= 8'h00;
        end
    end

    // ---------------------------------------------------------------
    // checks
    // ---------------------------------------------------------------
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (sys_rst);

    nmi_on_show_a: assert property (state_r == KMS_SHOW |=> nmi_r && state_r == KMS_HALT)
        else $error("nmi not raised on keystroke");
    halt_scan_a: assert property (state_r == KMS_HALT && !rd_key |=> drive_n_r == {COLS{1'b1}})
        else $error("scanning during halt");
    nmi_clear_a: assert property (state_r == KMS_HALT && rd_key |=> !nmi_r)
        else $error("nmi not cleared on read");
    bounce_time_a: assert property ($rose(state_r == KMS_BOUNCE) |-> state_r == KMS_BOUNCE [*3])
        else $error("debounce too short");
    break_code_a: assert property (state_r == KMS_SHOW && !cand_press_r |=> key_r == make_code + KMS_BREAK_OFS)
        else $error("bad break code");
    typ_arm_a: assert property (new_press |=> typ_r == 32'(DELAY_CYC - 1) && !typ_due_r)
        else $error("typematic not armed");
    typ_stop_a: assert property (state_r == KMS_SHOW && !cand_press_r |=> !typ_due_r)
        else $error("repeat after release");
    irq1_write_a: assert property (io_wr && io_addr == KMS_ADDR_XLAT |=> irq1_r && xlat_r == $past(io_wdata))
        else $error("level-1 request missing");

    press_c: cover property (state_r == KMS_SHOW && cand_press_r);
    release_c: cover property (state_r == KMS_SHOW && !cand_press_r);
    repeat_c: cover property (state_r == KMS_SCAN && typ_due_r);
    xlat_c: cover property (io_wr && io_addr == KMS_ADDR_XLAT);
endmodule

//--- kms_key_matrix.sv
// model: key switch matrix with pull-up sense lines
`timescale 1ns/1ps
module kms_key_matrix (
    input  wire logic [9:0]  drive_n,
    input  wire logic [79:0] pressed,
    output logic      [7:0]  sense_n
);
    // an idle or unselected row floats high through its pull-up
    always_comb begin
        sense_n = 8'hFF;
        for (int c = 0; c < 10; c++) begin
            for (int r = 0; r < 8; r++) begin
                if (!drive_n[c] && pressed[c*8+r]) begin
                    sense_n[r] = 1'b0;
                end
            end
        end
    end
endmodule

//--- tb_keyboard_matrix_scanner.sv
// testbench: keyboard matrix scanner keystroke, typematic and register checks
`timescale 1ns/1ps
module tb_keyboard_matrix_scanner;
    import kms_pkg::*;
    localparam int DLY = 200;
    localparam int REP = 50;
    logic        ref_clk    = 1'b0;
    logic        sys_rst    = 1'b1;
    logic [9:0]  drive_n_r;
    logic [7:0]  sense_n;
    logic [79:0] pressed    = '0;
    logic [7:0]  io_addr    = 8'h00;
    logic [7:0]  io_wdata   = 8'h00;
    logic        io_wr      = 1'b0;
    logic        io_rd      = 1'b0;
    logic [7:0]  io_rdata_r;
    logic        nmi_r;
    logic        irq1_r;
    int          err_count  = 0;
    int          n_compared = 0;
    int          t;
    int          k;

    always #25 ref_clk = ~ref_clk;

    kms_scanner #(.ROWS(8), .COLS(10), .DEBOUNCE_CYC(20), .DELAY_CYC(DLY), .REPEAT_CYC(REP)) dut (
        .ref_clk    (ref_clk),
        .sys_rst    (sys_rst),
        .drive_n_r  (drive_n_r),
        .sense_n    (sense_n),
        .io_addr    (io_addr),
        .io_wdata   (io_wdata),
        .io_wr      (io_wr),
        .io_rd      (io_rd),
        .io_rdata_r (io_rdata_r),
        .nmi_r      (nmi_r),
        .irq1_r     (irq1_r)
    );

    kms_key_matrix keys (
        .drive_n (drive_n_r),
        .pressed (pressed),
        .sense_n (sense_n)
    );

    // --------------------------------------------
    // report, check, wait and bus tasks
    // --------------------------------------------
    task automatic results();
        $display("compared %0d mismatches %0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string msg);
        n_compared++;
        if (got !== exp) begin
            err_count++;
            $display("Error at %0t: %s got %h exp %h", $time, msg, got, exp);
        end
    endtask

    task automatic step();
        @(posedge ref_clk);
        #1;
    endtask

    task automatic rd(input logic [7:0] a);
        step();
        io_addr = a;
        io_rd = 1'b1;
        step();
        io_rd = 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        step();
        io_addr = a;
        io_wdata = d;
        io_wr = 1'b1;
        step();
        io_wr = 1'b0;
    endtask

    task automatic wait_nmi(output int n);
        n = 0;
        while (nmi_r !== 1'b1) begin
            step();
            n++;
            if (n > 2000) begin
                err_count++;
                $display("Error at %0t: no keystroke interrupt", $time);
                results();
            end
        end
    endtask

    // set a key, wait for its keystroke, read and check the code
    task automatic key_ev(input int kk, input logic v, input logic [7:0] exp);
        pressed[kk] = v;
        wait_nmi(t);
        repeat (2) step();
        chk({7'h0, &drive_n_r}, 8'h01, "scan halted");
        rd(KMS_ADDR_KEY);
        chk(io_rdata_r, exp, "key code");
        chk({7'h0, nmi_r}, 8'h00, "nmi clear after read");
    endtask

    task automatic chk_win(input int exp);
        chk({7'h0, (t + 4 >= exp - 5) && (t + 4 <= exp + 80)}, 8'h01, "typematic interval");
    endtask

    // --------------------------------------------
    // main sequence
    // --------------------------------------------
    initial begin
        repeat (6) step();
        chk({7'h0, &drive_n_r}, 8'h01, "drive idle in reset");
        sys_rst = 1'b0;
        chk({6'h0, nmi_r, irq1_r}, 8'h00, "requests after reset");
        key_ev(0, 1'b1, 8'h11);
        key_ev(0, 1'b1, 8'h11);
        chk_win(DLY);
        key_ev(0, 1'b1, 8'h11);
        chk_win(REP);
        key_ev(10, 1'b1, 8'h1B);
        key_ev(10, 1'b1, 8'h1B);
        chk_win(DLY);
        pressed = '0;
        repeat (600) begin
            step();
            if (nmi_r === 1'b1) begin
                rd(KMS_ADDR_KEY);
            end
        end
        for (int i = 0; i < 12; i++) begin
            k = (i == 0) ? 60 : 65 + i;
            key_ev(k, 1'b1, (i == 0) ? 8'h56 : 8'(i));
            key_ev(k, 1'b0, ((i == 0) ? 8'h56 : 8'(i)) + KMS_BREAK_OFS);
        end
        pressed[5] = 1'b1;
        repeat (12) step();
        pressed[5] = 1'b0;
        repeat (DLY + 100) step();
        chk({7'h0, nmi_r}, 8'h00, "no glitch or repeat");
        wr(KMS_ADDR_XLAT, 8'hA5);
        chk({7'h0, irq1_r}, 8'h01, "level-1 request");
        wr(KMS_ADDR_KEY, 8'h3C);
        rd(KMS_ADDR_KEY);
        chk(io_rdata_r, 8'h8B, "code register read-only");
        rd(KMS_ADDR_XLAT);
        chk(io_rdata_r, 8'hA5, "translated code");
        chk({7'h0, irq1_r}, 8'h00, "level-1 cleared");
        wr(KMS_ADDR_XLAT, 8'h5A);
        rd(KMS_ADDR_XLAT);
        chk(io_rdata_r, 8'h5A, "translated code bits");
        rd(8'h00);
        chk(io_rdata_r, 8'h00, "unmapped read");
        results();
    end
endmodule
